// File: hdl/delay_timer.sv
/*
 Delay timer: done rises CYCLES clocks after start rises, restarts on start low.
 Assumes a synchronous active-high reset.
*/
`timescale 1ns/1ps
module delay_timer #(
    parameter int CYCLES = 1000,
    parameter int W = 26
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    delay_if.timer dly
);
    logic [W-1:0] cnt_ff;
    logic done_ff;
    // Counter restarts as soon as the start condition drops
    always_ff @(posedge ref_clk_i) begin
        if (reset_i || !dly.start) begin
            cnt_ff <= '0;
            done_ff <= 1'b0;
        end else if (cnt_ff >= W'(CYCLES - 1)) begin
            done_ff <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + W'(1);
        end
    end
    assign dly.done = done_ff;
endmodule

// File: hdl/power_seq_ctrl.sv
/*
 Power source selection, on/off latch, rail sequencing and reset timing.
 Assumes comparator and regulation levels arrive asynchronously and are
 synchronised here; open-drain pins are given as output and enable.
*/
// What this block does
// - Low-battery flag pulled low while battery sense is below reference.
// - Wall sense high: power from external node, USB pass switch open.
// - External-power-good low on wall present or USB present unsuspended.
// - No external-node power until its detector reports it up.
// - USB switch closed only with USB up, not suspended, no wall.
// - High-current select high picks 500 mA, low picks 100 mA.
// - Peripheral rail switch closes 0.8 ms after core in regulation.
// - Card rail switch closes 0.5 ms after core in regulation.
// - Suspend high disables USB power and opens the pass switch.
// - Power button low turns the device on.
// - Button-state output follows the power button input.
// - Device stays on while host holds hold-on high.
// - Mode high permits pulse skipping, low forces fixed frequency.
// - Fixed frequency forced when powered from USB or wall.
// - Fixed frequency forced during the initial reset delay.
// - Reset held low until core and main good plus 262 ms.
// - Reset pulled low at once when core or main falls out.
// - Reset pulled low at power-off.
// - Internal rail first, then core, then peripheral and card rails.
// - USB below threshold means lost; pass switch opens.
// - Internal rail discharged when the device is off.
`timescale 1ns/1ps
`include "power_seq_consts.svh"
module power_seq_ctrl #(
    parameter int PERIPH_CYCLES = `PERIPH_DELAY_CYC,
    parameter int CARD_CYCLES = `CARD_DELAY_CYC,
    parameter int RESET_CYCLES = `RESET_DELAY_CYC
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic battery_low_cmp_i,
    input wire logic wall_sense_above_i,
    input wire logic ext_node_ok_i,
    input wire logic usb_ok_i,
    input wire logic suspend_i,
    input wire logic usb_high_current_sel_i,
    input wire logic power_button_n_i,
    input wire logic host_hold_on_i,
    input wire logic mode_i,
    input wire logic internal_rail_ok_i,
    input wire logic core_feedback_ok_i,
    input wire logic main_ok_i,
    output logic low_battery_flag_o,
    output logic low_battery_flag_oe_n_o,
    output logic external_power_good_n_o,
    output logic external_power_good_n_oe_n_o,
    output logic button_state_n_o,
    output logic button_state_n_oe_n_o,
    output logic reset_n_o,
    output logic reset_n_oe_n_o,
    output logic usb_switch_on_o,
    output logic usb_limit_500_o,
    output logic use_external_node_o,
    output power_seq_pkg::source_e source_o,
    output logic internal_rail_en_o,
    output logic internal_rail_discharge_o,
    output logic core_rail_en_o,
    output logic peripheral_rail_on_o,
    output logic card_rail_on_o,
    output logic fixed_freq_o
);
    import power_seq_pkg::*;

    localparam int NSYNC = 12;
    logic [NSYNC-1:0] raw;
    logic [NSYNC-1:0] syn;
    logic bat_low_s, wall_s, ext_ok_s, usb_s, susp_s, hc_s;
    logic btn_n_s, hold_s, mode_s, int_ok_s, core_ok_s, main_ok_s;

    assign raw = {battery_low_cmp_i, wall_sense_above_i, ext_node_ok_i, usb_ok_i,
                  suspend_i, usb_high_current_sel_i, power_button_n_i, host_hold_on_i,
                  mode_i, internal_rail_ok_i, core_feedback_ok_i, main_ok_i};

    // Button idles high so a reset does not look like a press
    sync2 #(.W(NSYNC), .INIT(12'h020)) u_sync (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .d_i(raw),
        .q_o(syn)
    );
    assign {bat_low_s, wall_s, ext_ok_s, usb_s, susp_s, hc_s,
            btn_n_s, hold_s, mode_s, int_ok_s, core_ok_s, main_ok_s} = syn;

    // Source selection; the analog detectors own their hysteresis
    logic usb_path;
    logic ext_ok_any;
    assign usb_path = usb_s && !susp_s && !wall_s;
    assign ext_ok_any = wall_s || usb_path;

    logic usb_sw_ff;
    logic lim500_ff;
    logic use_ext_ff;
    source_e src_ff;
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            usb_sw_ff <= 1'b0;
            lim500_ff <= 1'b0;
            use_ext_ff <= 1'b0;
            src_ff <= SRC_BATTERY;
        end else begin
            usb_sw_ff <= usb_path;
            lim500_ff <= hc_s;
            // External node only used once its detector says it is up
            use_ext_ff <= ext_ok_any && ext_ok_s;
            if (wall_s && ext_ok_s) begin
                src_ff <= SRC_WALL;
            end else if (usb_path && ext_ok_s) begin
                src_ff <= SRC_USB;
            end else begin
                src_ff <= SRC_BATTERY;
            end
        end
    end

    // Open-drain flags: value always 0, enable low pulls the pin
    logic bat_oe_n_ff;
    logic epg_oe_n_ff;
    logic btn_oe_n_ff;
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            bat_oe_n_ff <= 1'b1;
            epg_oe_n_ff <= 1'b1;
            btn_oe_n_ff <= 1'b1;
        end else begin
            bat_oe_n_ff <= !bat_low_s;
            epg_oe_n_ff <= !(wall_s || (usb_s && !susp_s));
            btn_oe_n_ff <= btn_n_s;
        end
    end

    // On/off: button or hold-on starts it; either one held keeps it on
    seq_state_e state_ff;
    logic on_req;
    logic press_ff;
    assign on_req = !btn_n_s || hold_s;

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            press_ff <= 1'b0;
        end else begin
            // Releasing the button before hold-on rises turns the device off
            press_ff <= !btn_n_s;
        end
    end

    delay_if periph_d ();
    delay_if card_d ();
    delay_if reset_d ();

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            state_ff <= ST_OFF;
        end else begin
            case (state_ff)
                ST_OFF: begin
                    if (on_req) begin
                        state_ff <= ST_INT_UP;
                    end
                end
                ST_INT_UP: begin
                    if (!on_req) begin
                        state_ff <= ST_OFF;
                    end else if (int_ok_s) begin
                        state_ff <= ST_CORE_UP;
                    end
                end
                ST_CORE_UP: begin
                    if (!on_req) begin
                        state_ff <= ST_OFF;
                    end else if (core_ok_s) begin
                        state_ff <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (!on_req) begin
                        state_ff <= ST_OFF;
                    end
                end
                default: begin
                    state_ff <= ST_OFF;
                end
            endcase
        end
    end

    logic is_on;
    logic is_run;
    assign is_on = (state_ff != ST_OFF);
    assign is_run = (state_ff == ST_RUN);

    // Rail switches wait for core regulation plus their own delay
    assign periph_d.start = is_run && core_ok_s;
    assign card_d.start = is_run && core_ok_s;
    assign reset_d.start = is_run && core_ok_s && main_ok_s;

    delay_timer #(.CYCLES(PERIPH_CYCLES), .W(`TIMER_W)) u_periph (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .dly(periph_d)
    );
    delay_timer #(.CYCLES(CARD_CYCLES), .W(`TIMER_W)) u_card (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .dly(card_d)
    );
    delay_timer #(.CYCLES(RESET_CYCLES), .W(`TIMER_W)) u_reset (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .dly(reset_d)
    );

    logic int_en_ff, dis_ff, core_en_ff, periph_ff, card_ff;
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            int_en_ff <= 1'b0;
            dis_ff <= 1'b1;
            core_en_ff <= 1'b0;
            periph_ff <= 1'b0;
            card_ff <= 1'b0;
        end else begin
            int_en_ff <= is_on;
            dis_ff <= !is_on;
            core_en_ff <= is_on && (state_ff != ST_INT_UP);
            periph_ff <= periph_d.done && periph_d.start;
            card_ff <= card_d.done && card_d.start;
        end
    end

    // Reset released only after the full timer; drops at once on any fault
    logic rst_oe_n_ff;
    logic startup_ff;
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            rst_oe_n_ff <= 1'b0;
        end else begin
            rst_oe_n_ff <= reset_d.done && reset_d.start;
        end
    end

    // Startup window ends at the first reset release after turn-on
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            startup_ff <= 1'b1;
        end else if (!is_on) begin
            startup_ff <= 1'b1;
        end else if (rst_oe_n_ff) begin
            startup_ff <= 1'b0;
        end
    end

    logic ff_ff;
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            ff_ff <= 1'b1;
        end else begin
            ff_ff <= !mode_s || ext_ok_any || startup_ff;
        end
    end

    assign low_battery_flag_o = 1'b0;
    assign low_battery_flag_oe_n_o = bat_oe_n_ff;
    assign external_power_good_n_o = 1'b0;
    assign external_power_good_n_oe_n_o = epg_oe_n_ff;
    assign button_state_n_o = 1'b0;
    assign button_state_n_oe_n_o = btn_oe_n_ff;
    assign reset_n_o = 1'b0;
    assign reset_n_oe_n_o = rst_oe_n_ff;
    assign usb_switch_on_o = usb_sw_ff;
    assign usb_limit_500_o = lim500_ff;
    assign use_external_node_o = use_ext_ff;
    assign source_o = src_ff;
    assign internal_rail_en_o = int_en_ff;
    assign internal_rail_discharge_o = dis_ff;
    assign core_rail_en_o = core_en_ff;
    assign peripheral_rail_on_o = periph_ff;
    assign card_rail_on_o = card_ff;
    assign fixed_freq_o = ff_ff;

    property p_usb_switch;
        @(posedge ref_clk_i) disable iff (reset_i)
        usb_sw_ff |-> $past(usb_s && !susp_s && !wall_s);
    endproperty
    a_usb_switch: assert property (p_usb_switch) else $error("usb switch closed illegally");

    property p_suspend;
        @(posedge ref_clk_i) disable iff (reset_i)
        susp_s |=> !usb_sw_ff;
    endproperty
    a_suspend: assert property (p_suspend) else $error("usb switch closed in suspend");

    property p_wall;
        @(posedge ref_clk_i) disable iff (reset_i)
        (wall_s && ext_ok_s) |=> (src_ff == SRC_WALL) && !usb_sw_ff;
    endproperty
    a_wall: assert property (p_wall) else $error("wall not preferred");

    property p_batflag;
        @(posedge ref_clk_i) disable iff (reset_i)
        bat_low_s |=> !bat_oe_n_ff;
    endproperty
    a_batflag: assert property (p_batflag) else $error("low battery flag not pulled");

    property p_epg;
        @(posedge ref_clk_i) disable iff (reset_i)
        (usb_s && !susp_s && !wall_s) |=> !epg_oe_n_ff;
    endproperty
    a_epg: assert property (p_epg) else $error("power good not pulled");

    property p_button;
        @(posedge ref_clk_i) disable iff (reset_i)
        !btn_n_s ##1 !btn_n_s |-> !btn_oe_n_ff;
    endproperty
    a_button: assert property (p_button) else $error("button state not following");

    property p_rst_fault;
        @(posedge ref_clk_i) disable iff (reset_i)
        (!core_ok_s || !main_ok_s) |=> !rst_oe_n_ff;
    endproperty
    a_rst_fault: assert property (p_rst_fault) else $error("reset not pulled on fault");

    property p_rst_off;
        @(posedge ref_clk_i) disable iff (reset_i)
        !is_on |=> ##1 !rst_oe_n_ff;
    endproperty
    a_rst_off: assert property (p_rst_off) else $error("reset not pulled when off");

    property p_periph_order;
        @(posedge ref_clk_i) disable iff (reset_i)
        $rose(periph_ff) |-> $past(core_ok_s && is_run);
    endproperty
    a_periph_order: assert property (p_periph_order) else $error("peripheral before core");

    property p_startup_ff;
        @(posedge ref_clk_i) disable iff (reset_i)
        (is_on && !rst_oe_n_ff && startup_ff) |=> ff_ff;
    endproperty
    a_startup_ff: assert property (p_startup_ff) else $error("pulse skip during startup");

    property p_discharge;
        @(posedge ref_clk_i) disable iff (reset_i)
        (state_ff == ST_OFF) |=> dis_ff && !int_en_ff;
    endproperty
    a_discharge: assert property (p_discharge) else $error("internal rail not discharged");
endmodule

// File: hdl/sync2.sv
/*
 Two-flop level synchroniser for a bus of asynchronous levels.
 Assumes a synchronous active-high reset.
*/
`timescale 1ns/1ps
module sync2 #(
    parameter int W = 8,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            meta_ff <= INIT;
            q_ff <= INIT;
        end else begin
            meta_ff <= d_i;
            q_ff <= meta_ff;
        end
    end
    assign q_o = q_ff;
endmodule

// File: shared/delay_if.sv
/*
 Interface between the sequencer and one delay timer.
 Assumes one clock domain.
*/
`timescale 1ns/1ps
interface delay_if;
    logic start;
    logic done;
    modport ctrl (output start, input done);
    modport timer (input start, output done);
endinterface

// File: shared/power_seq_consts.svh
/*
 Timing counts and reset values for the power source and sequence control.
 Assumes a 200 MHz time base clock.
*/
`ifndef POWER_SEQ_CONSTS_SVH
`define POWER_SEQ_CONSTS_SVH

`define CLK_MHZ 200
`define PERIPH_DELAY_US 800
`define CARD_DELAY_US 500
`define RESET_DELAY_MS 262
`define PERIPH_DELAY_CYC (`PERIPH_DELAY_US * `CLK_MHZ)
`define CARD_DELAY_CYC (`CARD_DELAY_US * `CLK_MHZ)
`define RESET_DELAY_CYC (`RESET_DELAY_MS * 1000 * `CLK_MHZ)
`define TIMER_W 26
`define RST_RELEASED 1'b1

`endif

// File: shared/power_seq_pkg.sv
/*
 Types for the power source and sequence control.
 Assumes nothing of its surroundings.
*/
package power_seq_pkg;
    typedef enum logic [2:0] {
        ST_OFF,
        ST_INT_UP,
        ST_CORE_UP,
        ST_RUN
    } seq_state_e;
    typedef enum logic [1:0] {
        SRC_BATTERY,
        SRC_USB,
        SRC_WALL
    } source_e;
endpackage

// File: tb/host_usb_model.sv
/*
 Host processor and USB controller model: hold-on, suspend, current select.
 Assumes the bench gives commands and the wire level of the button status pin.
*/
`timescale 1ns/1ps
module host_usb_model #(
    parameter int HOLD_DLY = 4
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic want_on_i,
    input wire logic susp_cmd_i,
    input wire logic hp_cmd_i,
    input wire logic button_level_i,
    output logic host_hold_on_o,
    output logic suspend_o,
    output logic usb_high_current_sel_o
);
    int cnt;
    initial begin
        host_hold_on_o = 1'b0;
        suspend_o = 1'b0;
        usb_high_current_sel_o = 1'b0;
        cnt = 0;
    end
    // Firmware needs a few cycles to wake before it holds the device on
    always @(posedge ref_clk_i) begin
        #1;
        suspend_o = susp_cmd_i;
        usb_high_current_sel_o = hp_cmd_i;
        if (reset_i || !want_on_i) begin
            cnt = 0;
            host_hold_on_o = 1'b0;
        end else if (!button_level_i || host_hold_on_o) begin
            cnt = cnt + 1;
            if (cnt >= HOLD_DLY) begin
                host_hold_on_o = 1'b1;
            end
        end
    end
endmodule

// File: tb/tb_top.sv
/*
 Self-checking bench for the power source and sequence control.
 Assumes pull-ups on open-drain pins, so each pin level equals its oe_n.
*/
`timescale 1ns/1ps
module tb_top;
    import power_seq_pkg::*;
    localparam int PER = 20;
    localparam int CRD = 10;
    localparam int RST = 50;
    logic ref_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic bat_low = 1'b0, wall = 1'b0, ext_ok = 1'b0, usb_ok = 1'b0, btn_n = 1'b1;
    logic mode = 1'b0, int_ok = 1'b0, core_ok = 1'b0, main_ok = 1'b0;
    logic want_on = 1'b0, susp_cmd = 1'b0, hp_cmd = 1'b0, drop_core = 1'b0, drop_main = 1'b0;
    logic hold, susp, hp, lb_oe, epg_oe, btn_oe, rst_oe, usb_sw, lim500, use_ext;
    logic int_en, dis, core_en, per_on, card_on, fixed;
    source_e src;
    int fail_count = 0;
    int checks = 0;
    int cyc = 0;
    int t_core, t_card, t_per, t_main, t_rel;
    logic [31:0] r;
    logic bad_seq, bad_ff;
    logic [3:0] od_val;

    power_seq_ctrl #(.PERIPH_CYCLES(PER), .CARD_CYCLES(CRD), .RESET_CYCLES(RST)) dut_u (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .battery_low_cmp_i(bat_low),
        .wall_sense_above_i(wall), .ext_node_ok_i(ext_ok), .usb_ok_i(usb_ok),
        .suspend_i(susp), .usb_high_current_sel_i(hp), .power_button_n_i(btn_n),
        .host_hold_on_i(hold), .mode_i(mode), .internal_rail_ok_i(int_ok),
        .core_feedback_ok_i(core_ok), .main_ok_i(main_ok), .low_battery_flag_o(od_val[0]),
        .low_battery_flag_oe_n_o(lb_oe), .external_power_good_n_o(od_val[1]),
        .external_power_good_n_oe_n_o(epg_oe), .button_state_n_o(od_val[2]),
        .button_state_n_oe_n_o(btn_oe), .reset_n_o(od_val[3]), .reset_n_oe_n_o(rst_oe),
        .usb_switch_on_o(usb_sw), .usb_limit_500_o(lim500), .use_external_node_o(use_ext),
        .source_o(src), .internal_rail_en_o(int_en), .internal_rail_discharge_o(dis),
        .core_rail_en_o(core_en), .peripheral_rail_on_o(per_on), .card_rail_on_o(card_on),
        .fixed_freq_o(fixed));

    host_usb_model model_u (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .want_on_i(want_on), .susp_cmd_i(susp_cmd),
        .hp_cmd_i(hp_cmd), .button_level_i(btn_oe), .host_hold_on_o(hold),
        .suspend_o(susp), .usb_high_current_sel_o(hp));

    initial begin
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end

    // Rails settle 1 ns after the clock edge that sets their enable; drops model a sagging rail
    always @(posedge ref_clk_i) begin
        #1;
        int_ok = int_en;
        core_ok = core_en & int_ok & !drop_core;
        main_ok = per_on & !drop_main;
    end

    always @(posedge ref_clk_i) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    function automatic source_e exp_src(input logic w, e, u, s);
        if (e && w) return SRC_WALL;
        if (e && u && !s) return SRC_USB;
        return SRC_BATTERY;
    endfunction

    // Latency slack of synchronisers and state steps
    function automatic logic in_rng(input int v, input int n);
        return v >= n && v <= n + 8;
    endfunction

    initial begin
        r = $urandom(32'h1e3c);
        tick(3);
        reset_i = 1'b0;
        check("reset pin", rst_oe, 1'b0);
        check("discharge", dis, 1'b1);
        check("fixed freq", fixed, 1'b1);
        check("usb switch", usb_sw, 1'b0);
        check("rails", {int_en, core_en, per_on, card_on}, 4'h0);
        $display("test reset done");

        want_on = 1'b1;
        btn_n = 1'b0;
        // Mode high so only the startup window can force fixed frequency
        mode = 1'b1;
        {t_core, t_card, t_per, t_main, t_rel, bad_seq, bad_ff} = '0;
        for (int i = 0; i < 400 && t_rel == 0; i++) begin
            tick(1);
            if (hold) btn_n = 1'b1;
            if (core_ok && t_core == 0) t_core = cyc;
            if (card_on && t_card == 0) t_card = cyc;
            if (per_on && t_per == 0) t_per = cyc;
            if (main_ok && t_main == 0) t_main = cyc;
            if (rst_oe && t_rel == 0) t_rel = cyc;
            if ((core_en && !int_en) || ((per_on || card_on) && !core_ok)) bad_seq = 1'b1;
            if (!rst_oe && !fixed) bad_ff = 1'b1;
        end
        check("sequence order", bad_seq, 1'b0);
        check("startup fixed", bad_ff, 1'b0);
        check("card delay", in_rng(t_card - t_core, CRD), 1'b1);
        check("periph delay", in_rng(t_per - t_core, PER), 1'b1);
        check("reset delay", in_rng(t_rel - t_main, RST), 1'b1);
        $display("test power up done");

        for (int i = 0; i < 60; i++) begin
            r = $urandom();
            {bat_low, wall, ext_ok, usb_ok, susp_cmd, hp_cmd, btn_n, mode} = r[7:0];
            if (i < 16) {wall, ext_ok, usb_ok, susp_cmd} = 4'(i);
            tick(6);
            check("low battery", lb_oe, !bat_low);
            check("use ext", use_ext, ext_ok & (wall | usb_ok & !susp_cmd));
            check("ext power good", epg_oe, !(wall | usb_ok & !susp_cmd));
            check("usb switch", usb_sw, usb_ok & !susp_cmd & !wall);
            check("source", src, exp_src(wall, ext_ok, usb_ok, susp_cmd));
            if (!susp_cmd) check("usb limit", lim500, hp_cmd);
            check("button state", btn_oe, btn_n);
            check("fixed", fixed, !mode | wall | (usb_ok & !susp_cmd));
        end
        $display("test source select done");

        btn_n = 1'b1;
        for (int k = 0; k < 2; k++) begin
            drop_core = (k == 0);
            drop_main = (k == 1);
            tick(6);
            check("reset on drop", rst_oe, 1'b0);
            drop_core = 1'b0;
            drop_main = 1'b0;
            tick(RST - 4);
            check("reset restart", rst_oe, 1'b0);
            for (int i = 0; i < PER + RST + 40 && rst_oe !== 1'b1; i++) tick(1);
            check("reset release", rst_oe, 1'b1);
        end
        $display("test rail drop done");

        want_on = 1'b0;
        tick(8);
        check("reset off", rst_oe, 1'b0);
        check("discharge off", {dis, int_en}, 2'b10);
        check("rails off", {core_en, per_on, card_on}, 3'h0);
        check("open drain values", od_val, 4'h0);
        btn_n = 1'b0;
        tick(8);
        check("button on", int_en, 1'b1);
        btn_n = 1'b1;
        tick(8);
        check("no hold", int_en, 1'b0);
        $display("test power off done");
        tally_and_finish();
    end
endmodule
